/* verilog/hp_gpio_pkg.sv */
package hp_gpio_pkg;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_FUNC_SEL = 8'h00;
  localparam logic [7:0] OFS_DATA_DIR = 8'h04;
  localparam logic [7:0] OFS_DATA_LVL = 8'h08;
  localparam logic [7:0] OFS_CTRL_DIR = 8'h0C;
  localparam logic [7:0] OFS_CTRL_LVL = 8'h10;

  // ---------------------------------------------------------------
  // enable register field positions
  // ---------------------------------------------------------------
  localparam int BIT_SEL_ADDR_UPPER = 12;
  localparam int BIT_SEL_ADDR_LOWER = 11;
  localparam int BIT_SEL_DATA_UPPER = 8;
  localparam int BIT_SEL_DATA_LOWER = 7;
  localparam int BIT_SEL_IRQ_OUT = 6;
  localparam int BIT_SEL_BYTE_ID = 4;
  localparam int BIT_SEL_ADDR_STROBE = 2;
  localparam int BIT_SEL_ACCESS_CTRL = 1;
  localparam int BIT_SEL_STROBE_GRP = 0;

  // writable masks, reserved bits read zero
  localparam logic [15:0] FUNC_SEL_MASK = 16'h19D7;
  localparam logic [15:0] CTRL_MASK = 16'h01FF;

  // ---------------------------------------------------------------
  // control pin positions in the control registers
  // ---------------------------------------------------------------
  localparam int CP_ADDR_STROBE = 0;
  localparam int CP_SELECT = 1;
  localparam int CP_STROBE_ONE = 2;
  localparam int CP_STROBE_TWO = 3;
  localparam int CP_READ_WRITE = 4;
  localparam int CP_BYTE_ID = 5;
  localparam int CP_ACCESS_CTRL1 = 6;
  localparam int CP_ACCESS_CTRL0 = 7;
  localparam int CP_IRQ_OUT = 8;

  // reset values
  localparam logic [15:0] RST_REG = 16'h0000;

  // ---------------------------------------------------------------
  // carrier types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    HTRANS_IDLE = 2'b00,
    HTRANS_BUSY = 2'b01,
    HTRANS_NSEQ = 2'b10,
    HTRANS_SEQ = 2'b11
  } htrans_t;

  typedef struct packed {
    logic [15:0] func_sel;
    logic [15:0] data_dir;
    logic [15:0] data_out;
    logic [15:0] ctrl_dir;
    logic [15:0] ctrl_out;
    logic wr_pend;
    logic rd_pend;
    logic [7:0] addr;
    logic [31:0] rdata;
  } state_t;

  // pin bundle, output enable active low
  typedef struct packed {
    logic [15:0] data_o;
    logic [15:0] data_oe_n;
    logic [8:0] ctrl_o;
    logic [8:0] ctrl_oe_n;
  } pins_t;

endpackage

/* verilog/host_port_pin_gpio.sv */
// Added by the designer: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
// Functional notes
// RULE_01: enable register reachable only over the internal cpu bus.
// RULE_02: bit 12 and bit 11 hand upper and lower address banks to gpio.
// RULE_03: address bank enables act only in sixteen-bit nonmultiplexed mode.
// RULE_04: bit 8 and bit 7 hand upper and lower data banks to gpio.
// RULE_05: upper data bank enable acts only in sixteen-bit mode.
// RULE_06: bit 6 hands the interrupt output pin to gpio.
// RULE_07: bit 4 hands the byte identification pin to gpio.
// RULE_08: bit 2 hands the address strobe pin to gpio.
// RULE_09: strobe and byte id enables act only in eight-bit mode.
// RULE_10: bit 1 hands both access control pins to gpio.
// RULE_11: bit 0 hands select, strobes, read/write to gpio if port disabled.
// RULE_12: software keeps bit 0 clear while the port enable pin is high.
// RULE_13: software writes zeros to reserved bits; enables reset to zero.
// RULE_14: each direction bit: zero input, one output, any mix.
// RULE_15: input pin data bit reads pin level; writes ignored.
// RULE_16: output pin data bit drives pin low or high.
// RULE_17: data pair maps bit n to data pin n; reset zero.
// RULE_18: data bits act only when their bank is gpio enabled.
// RULE_19: upper data direction and data usable only in sixteen-bit mode.
// RULE_20: control direction register, bit 8 interrupt pin, 15..9 reserved.
// RULE_21: strobe and byte id control bits usable only in eight-bit mode.
// RULE_22: non-gpio pins stay under host port control.
module host_port_pin_gpio
  import hp_gpio_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // port configuration
  input wire logic mode_16bit,
  input wire logic port_enable_input,
  // host port function side, oe active low
  input wire pins_t port_func,
  // pin side
  input wire logic [15:0] port_data_pins_i,
  input wire logic [15:0] port_addr_pins_i,
  input wire logic [8:0] ctrl_pins_i,
  input wire pins_t host_pins_unused_i,
  output pins_t pins,
  output logic [15:0] gpio_addr_upper_lower_sel,
  // pin levels back to host port logic
  output logic [15:0] port_data_to_func,
  output logic [8:0] ctrl_to_func
);

  state_t st;
  state_t next_st;
  logic [15:0] data_gpio;
  logic [8:0] ctrl_gpio;
  logic [15:0] data_in_rd;
  logic [15:0] ctrl_in_rd;
  logic [15:0] wval;

  // ---------------------------------------------------------------
  // effective gpio ownership per pin
  // ---------------------------------------------------------------

  // address bank grants, for the address pin logic outside
  always_comb begin
    gpio_addr_upper_lower_sel = '0;
    gpio_addr_upper_lower_sel[15:8] =
      {8{st.func_sel[BIT_SEL_ADDR_UPPER] & mode_16bit}}; // [RULE_02] [RULE_03]
    gpio_addr_upper_lower_sel[7:0] =
      {8{st.func_sel[BIT_SEL_ADDR_LOWER] & mode_16bit}}; // [RULE_02] [RULE_03]
  end

  // data bank grants
  always_comb begin
    data_gpio[7:0] = {8{st.func_sel[BIT_SEL_DATA_LOWER]}}; // [RULE_04] [RULE_18]
    data_gpio[15:8] = {8{st.func_sel[BIT_SEL_DATA_UPPER]
      & mode_16bit}}; // [RULE_04] [RULE_05] [RULE_19]
  end

  // control pin grants
  always_comb begin
    ctrl_gpio = '0;
    ctrl_gpio[CP_IRQ_OUT] = st.func_sel[BIT_SEL_IRQ_OUT]; // [RULE_06]
    ctrl_gpio[CP_BYTE_ID] = st.func_sel[BIT_SEL_BYTE_ID]
      & ~mode_16bit; // [RULE_07] [RULE_09] [RULE_21]
    ctrl_gpio[CP_ADDR_STROBE] = st.func_sel[BIT_SEL_ADDR_STROBE]
      & ~mode_16bit; // [RULE_08] [RULE_09] [RULE_21]
    ctrl_gpio[CP_ACCESS_CTRL0] = st.func_sel[BIT_SEL_ACCESS_CTRL]; // [RULE_10]
    ctrl_gpio[CP_ACCESS_CTRL1] = st.func_sel[BIT_SEL_ACCESS_CTRL]; // [RULE_10]
    ctrl_gpio[CP_SELECT] = st.func_sel[BIT_SEL_STROBE_GRP]
      & ~port_enable_input; // [RULE_11]
    ctrl_gpio[CP_STROBE_ONE] = ctrl_gpio[CP_SELECT]; // [RULE_11]
    ctrl_gpio[CP_STROBE_TWO] = ctrl_gpio[CP_SELECT]; // [RULE_11]
    ctrl_gpio[CP_READ_WRITE] = ctrl_gpio[CP_SELECT]; // [RULE_11]
  end

  // ---------------------------------------------------------------
  // pin drivers: gpio owns a pin or host port function does
  // ---------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (data_gpio[i]) begin
        pins.data_o[i] = st.data_out[i]; // [RULE_16] [RULE_17]
        pins.data_oe_n[i] = ~st.data_dir[i]; // [RULE_14]
      end else begin
        pins.data_o[i] = port_func.data_o[i]; // [RULE_22]
        pins.data_oe_n[i] = port_func.data_oe_n[i]; // [RULE_22]
      end
    end
    for (int j = 0; j < 9; j++) begin
      if (ctrl_gpio[j]) begin
        pins.ctrl_o[j] = st.ctrl_out[j]; // [RULE_16]
        pins.ctrl_oe_n[j] = ~st.ctrl_dir[j]; // [RULE_14] [RULE_20]
      end else begin
        pins.ctrl_o[j] = port_func.ctrl_o[j]; // [RULE_22]
        pins.ctrl_oe_n[j] = port_func.ctrl_oe_n[j]; // [RULE_22]
      end
    end
  end

  // pin levels to the host port, gpio pins shown idle low
  assign port_data_to_func = port_data_pins_i & ~data_gpio;
  assign ctrl_to_func = ctrl_pins_i & ~ctrl_gpio;

  // ---------------------------------------------------------------
  // read values of the level registers
  // ---------------------------------------------------------------
  always_comb begin
    data_in_rd = (st.data_dir & st.data_out)
      | (~st.data_dir & port_data_pins_i); // [RULE_15]
    ctrl_in_rd = ((st.ctrl_dir & st.ctrl_out)
      | (~st.ctrl_dir & {7'h00, ctrl_pins_i})) & CTRL_MASK; // [RULE_15]
  end

  // ---------------------------------------------------------------
  // ahb-lite slave, zero wait state, always okay
  // ---------------------------------------------------------------
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st.rdata;
  assign wval = hwdata[15:0];

  // next state of registers and bus phase
  always_comb begin
    next_st = st;
    next_st.wr_pend = 1'b0;
    next_st.rd_pend = 1'b0;
    // data phase of a write
    if (st.wr_pend) begin
      unique case (st.addr)
        OFS_FUNC_SEL: next_st.func_sel = wval & FUNC_SEL_MASK; // [RULE_01]
        OFS_DATA_DIR: next_st.data_dir = wval; // [RULE_14] [RULE_17]
        OFS_DATA_LVL: next_st.data_out = (wval & st.data_dir)
          | (st.data_out & ~st.data_dir); // [RULE_15] [RULE_16]
        OFS_CTRL_DIR: next_st.ctrl_dir = wval & CTRL_MASK; // [RULE_20]
        OFS_CTRL_LVL: next_st.ctrl_out = ((wval & st.ctrl_dir)
          | (st.ctrl_out & ~st.ctrl_dir)) & CTRL_MASK; // [RULE_15]
        default: next_st.func_sel = st.func_sel;
      endcase
    end
    // address phase
    if (hsel && hready && htrans[1]) begin
      next_st.addr = haddr[7:0];
      next_st.wr_pend = hwrite;
      next_st.rd_pend = ~hwrite;
      unique case (haddr[7:0])
        OFS_FUNC_SEL: next_st.rdata = {16'h0000, st.func_sel};
        OFS_DATA_DIR: next_st.rdata = {16'h0000, st.data_dir};
        OFS_DATA_LVL: next_st.rdata = {16'h0000, data_in_rd};
        OFS_CTRL_DIR: next_st.rdata = {16'h0000, st.ctrl_dir};
        OFS_CTRL_LVL: next_st.rdata = {16'h0000, ctrl_in_rd};
        default: next_st.rdata = 32'h00000000;
      endcase
    end
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0; // [RULE_13]
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------

  // strobe group never handed over while the host port is live
  a_strobe_group_gate: assert property ( // [RULE_11]
    @(posedge hclk) disable iff (!hresetn)
    port_enable_input |-> !ctrl_gpio[CP_SELECT])
    else $error("strobe group granted while port enabled");

  // upper data bank absent in eight-bit mode
  a_upper_data_mode: assert property ( // [RULE_05]
    @(posedge hclk) disable iff (!hresetn)
    !mode_16bit |-> data_gpio[15:8] == 8'h00)
    else $error("upper data bank granted in eight-bit mode");

  // strobe and byte id pins absent in sixteen-bit mode
  a_strobe_pin_mode: assert property ( // [RULE_09]
    @(posedge hclk) disable iff (!hresetn)
    mode_16bit |-> !ctrl_gpio[CP_ADDR_STROBE] && !ctrl_gpio[CP_BYTE_ID])
    else $error("strobe or byte id granted in sixteen-bit mode");

  // address banks absent in eight-bit mode
  a_addr_bank_mode: assert property ( // [RULE_03]
    @(posedge hclk) disable iff (!hresetn)
    !mode_16bit |-> gpio_addr_upper_lower_sel == 16'h0000)
    else $error("address bank granted in eight-bit mode");

  // enable register takes the masked write data
  a_func_sel_write: assert property ( // [RULE_01]
    @(posedge hclk) disable iff (!hresetn)
    st.wr_pend && st.addr == OFS_FUNC_SEL |=>
    st.func_sel == ($past(hwdata[15:0]) & FUNC_SEL_MASK))
    else $error("enable register write lost");

  // writes leave the data bits of input pins alone
  a_input_write_kept: assert property ( // [RULE_15]
    @(posedge hclk) disable iff (!hresetn)
    st.wr_pend && st.addr == OFS_DATA_LVL |=>
    ((st.data_out ^ $past(st.data_out)) & ~$past(st.data_dir)) == 16'h0)
    else $error("input data bit changed by write");

  // a gpio output pin follows its data bit
  a_gpio_drive: assert property ( // [RULE_16]
    @(posedge hclk) disable iff (!hresetn)
    data_gpio[0] && st.data_dir[0] |->
    !pins.data_oe_n[0] && pins.data_o[0] == st.data_out[0])
    else $error("gpio output not driven");

  // host function keeps the interrupt pin unless handed over
  a_host_keeps_pin: assert property ( // [RULE_22]
    @(posedge hclk) disable iff (!hresetn)
    !ctrl_gpio[CP_IRQ_OUT] |->
    pins.ctrl_oe_n[CP_IRQ_OUT] == port_func.ctrl_oe_n[CP_IRQ_OUT])
    else $error("host lost interrupt pin");

  // direction readback in the data phase
  a_read_data_reg: assert property ( // [RULE_14]
    @(posedge hclk) disable iff (!hresetn)
    hsel && hready && htrans[1] && !hwrite && haddr[7:0] == OFS_DATA_DIR
    |=> hrdata == {16'h0000, $past(st.data_dir)})
    else $error("direction readback wrong");

  // lower data bank follows its enable bit alone
  a_lower_data_grant: assert property ( // [RULE_04]
    @(posedge hclk) disable iff (!hresetn)
    data_gpio[7:0] == {8{st.func_sel[BIT_SEL_DATA_LOWER]}})
    else $error("lower data bank grant wrong");

  // interrupt pin follows its enable bit in both modes
  a_irq_pin_grant: assert property ( // [RULE_06]
    @(posedge hclk) disable iff (!hresetn)
    ctrl_gpio[CP_IRQ_OUT] == st.func_sel[BIT_SEL_IRQ_OUT])
    else $error("interrupt pin grant wrong");

  // both access control pins move together
  a_access_pair: assert property ( // [RULE_10]
    @(posedge hclk) disable iff (!hresetn)
    ctrl_gpio[CP_ACCESS_CTRL0] == ctrl_gpio[CP_ACCESS_CTRL1])
    else $error("access control pins split");

  // upper half of read data is always zero
  a_read_upper_zero: assert property ( // [RULE_20]
    @(posedge hclk) disable iff (!hresetn)
    hrdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");

  // host function keeps an upper data pin unless handed over
  a_host_keeps_data: assert property ( // [RULE_22]
    @(posedge hclk) disable iff (!hresetn)
    !data_gpio[15] |->
    pins.data_oe_n[15] == port_func.data_oe_n[15])
    else $error("host lost upper data pin");

endmodule

/* verification/pin_partner.sv */
`timescale 1ns/1ps
// ---------------------------------------------
// far side of the repurposed port pins
// ---------------------------------------------
module pin_partner
  import hp_gpio_pkg::*;
(
  // pins from the block
  input wire pins_t pins,
  // levels the outside circuitry drives
  input wire logic [15:0] ext_data,
  input wire logic [8:0] ext_ctrl,
  // resolved wire levels
  output logic [15:0] data_lvl,
  output logic [8:0] ctrl_lvl
);
  // block wins where its oe is low, far side elsewhere
  always_comb begin
    data_lvl = (pins.data_o & ~pins.data_oe_n) | (ext_data & pins.data_oe_n);
    ctrl_lvl = (pins.ctrl_o & ~pins.ctrl_oe_n) | (ext_ctrl & pins.ctrl_oe_n);
  end
endmodule

/* verification/test_host_port_pin_gpio.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; \
  $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module test_host_port_pin_gpio
  import hp_gpio_pkg::*;
;
  logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
  logic mode_16bit = 1'h1, port_enable_input = 1'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp;
  logic [31:0] hrdata;
  pins_t port_func = '0, pins;
  logic [15:0] ext_data = 16'h3C5A, dlvl, gsel, d2f;
  logic [8:0] ext_ctrl = 9'h0A5, clvl, c2f;
  int fails = 0, comparisons = 0;

  host_port_pin_gpio u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .mode_16bit(mode_16bit),
    .port_enable_input(port_enable_input), .port_func(port_func),
    .port_data_pins_i(dlvl), .port_addr_pins_i(16'h0),
    .ctrl_pins_i(clvl), .host_pins_unused_i('0), .pins(pins),
    .gpio_addr_upper_lower_sel(gsel), .port_data_to_func(d2f),
    .ctrl_to_func(c2f));
  pin_partner u_far (.pins(pins), .ext_data(ext_data),
    .ext_ctrl(ext_ctrl), .data_lvl(dlvl), .ctrl_lvl(clvl));

  // ---------------------------------------------
  // bus and report helpers
  // ---------------------------------------------
  task stop_test;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // bounded wait for hready high at an edge
  task rdy;
    for (int i = 0; i < 16; i++) begin
      @(posedge hclk);
      if (hreadyout === 1'h1) return;
    end
    fails++;
    stop_test();
  endtask
  // one single word transfer, address then data phase
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'h1;
    haddr <= {24'h0, a};
    htrans <= HTRANS_NSEQ;
    hwrite <= w;
    rdy();
    hsel <= 1'h0;
    htrans <= HTRANS_IDLE;
    hwdata <= d;
    rdy();
    rd = hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'h1, a, d);
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0);
    `CHK(rd, e);
  endtask
  // let a change reach the pins
  task settle;
    @(posedge hclk);
    #1;
  endtask
  task pins_mode(input logic m, input logic pe);
    @(posedge hclk);
    mode_16bit <= m;
    port_enable_input <= pe;
    settle();
  endtask

  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  task t_reset;
    for (int a = 0; a <= 20; a += 4)
      rdchk(a[7:0], 32'h0);
    `CHK(hresp, 1'h0);
    wr(OFS_FUNC_SEL, {16'h0, FUNC_SEL_MASK});
    rdchk(OFS_FUNC_SEL, {16'h0, FUNC_SEL_MASK});
    wr(OFS_CTRL_DIR, {16'h0, CTRL_MASK});
    rdchk(OFS_CTRL_DIR, {16'h0, CTRL_MASK});
    $display("test reset done");
  endtask
  task t_data;
    pins_mode(1'h1, 1'h0);
    wr(OFS_FUNC_SEL, 32'h0180);
    wr(OFS_DATA_DIR, 32'hFFFF);
    wr(OFS_DATA_LVL, 32'hA5C3);
    settle();
    `CHK(pins.data_oe_n, 16'h0000);
    `CHK(pins.data_o, 16'hA5C3);
    // mixed directions, input bits read the wire
    wr(OFS_DATA_DIR, 32'h00FF);
    wr(OFS_DATA_LVL, 32'hFFFF);
    settle();
    `CHK(pins.data_oe_n, 16'hFF00);
    rdchk(OFS_DATA_LVL, 32'h3CFF);
    $display("test data done");
  endtask
  task t_bank;
    @(posedge hclk);
    port_func.data_oe_n <= 16'hFFFF;
    port_func.data_o <= 16'h1234;
    wr(OFS_FUNC_SEL, 32'h0080);
    wr(OFS_DATA_DIR, 32'hFFFF);
    settle();
    `CHK(pins.data_oe_n, 16'hFF00);
    `CHK(pins.data_o[15:8], 8'h12);
    `CHK(d2f, 16'h3C00);
    wr(OFS_FUNC_SEL, 32'h0180);
    pins_mode(1'h0, 1'h0);
    `CHK(pins.data_oe_n, 16'hFF00);
    $display("test bank done");
  endtask
  task t_ctrl;
    @(posedge hclk);
    port_func.ctrl_oe_n <= 9'h1FF;
    wr(OFS_CTRL_DIR, 32'h01FF);
    wr(OFS_CTRL_LVL, 32'h0155);
    wr(OFS_FUNC_SEL, 32'h0057);
    pins_mode(1'h0, 1'h0);
    `CHK(pins.ctrl_oe_n, 9'h000);
    `CHK(pins.ctrl_o, 9'h155);
    `CHK(c2f, 9'h000);
    pins_mode(1'h0, 1'h1);
    `CHK(pins.ctrl_oe_n, 9'h01E);
    pins_mode(1'h1, 1'h0);
    `CHK(pins.ctrl_oe_n, 9'h021);
    wr(OFS_FUNC_SEL, 32'h1800);
    settle();
    `CHK(gsel, 16'hFFFF);
    pins_mode(1'h0, 1'h0);
    `CHK(gsel, 16'h0000);
    $display("test ctrl done");
  endtask

  // clock, reset, sequence and watchdog
  initial begin
    forever #10 hclk = ~hclk;
  end
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'h1;
    t_reset();
    t_data();
    t_bank();
    t_ctrl();
    stop_test();
  end
  initial begin
    #500000;
    fails++;
    stop_test();
  end
endmodule
